// file: core/d8t_map.vh
// Address map, field positions, reset values and selector codes of the
// dual 8-bit timer. Assumes a 16-bit CPU address, byte or word access.
`ifndef D8T_MAP_VH
`define D8T_MAP_VH

// ==========================================================
// Addresses
`define D8T_MSTP_ADDR 16'hff3c
`define D8T_TIMER_CONTROL_CH0_ADDR 16'hffb0
`define D8T_TIMER_CONTROL_CH1_ADDR 16'hffb1
`define D8T_CONTROL_STATUS_CH0_ADDR 16'hffb2
`define D8T_CONTROL_STATUS_CH1_ADDR 16'hffb3
`define D8T_CORA0_ADDR 16'hffb4
`define D8T_CORA1_ADDR 16'hffb5
`define D8T_CORB0_ADDR 16'hffb6
`define D8T_CORB1_ADDR 16'hffb7
`define D8T_CNT0_ADDR 16'hffb8
`define D8T_CNT1_ADDR 16'hffb9
`define D8T_BLOCK_HI 12'hffb

// ==========================================================
// Register pair index, address bits 3:1
`define D8T_IDX_TCR 3'h0
`define D8T_IDX_CONTROL_STATUS 3'h1
`define D8T_IDX_CORA 3'h2
`define D8T_IDX_CORB 3'h3
`define D8T_IDX_CNT 3'h4

// ==========================================================
// Reset values, counter maximum and module stop bit
`define D8T_MSTP_RST 16'h3fff
`define D8T_TCR_RST 8'h00
`define D8T_COR_RST 8'hff
`define D8T_CNT_RST 8'h00
`define D8T_CNT_MAX 8'hff
`define D8T_MSTP_BIT 12

// ==========================================================
// Field positions
`define D8T_TCR_CKS_LO 0
`define D8T_TCR_CCLR_LO 3
`define D8T_TCR_OVERFLOW_IRQ_EN 5
`define D8T_TCR_MATCH_A_IRQ_EN 6
`define D8T_TCR_MATCH_B_IRQ_EN 7
`define D8T_CONTROL_STATUS_OSA_LO 0
`define D8T_CONTROL_STATUS_OSB_LO 2
`define D8T_CONTROL_STATUS_RSV 4
`define D8T_CONTROL_STATUS_FLAG_LO 5

// ==========================================================
// Clock select codes
`define D8T_CKS_STOP 3'h0
`define D8T_CKS_DIV8 3'h1
`define D8T_CKS_DIV64 3'h2
`define D8T_CKS_DIV8192 3'h3
`define D8T_CKS_CASC 3'h4
`define D8T_CKS_EXT_RISE 3'h5
`define D8T_CKS_EXT_FALL 3'h6
`define D8T_CKS_EXT_BOTH 3'h7

// Clear select codes
`define D8T_CCLR_NONE 2'h0
`define D8T_CCLR_MATCH_A 2'h1
`define D8T_CCLR_MATCH_B 2'h2
`define D8T_CCLR_EXT 2'h3

// Output select codes
`define D8T_OS_KEEP 2'h0
`define D8T_OS_LOW 2'h1
`define D8T_OS_HIGH 2'h2
`define D8T_OS_TOGGLE 2'h3

// Prescaler taps
`define D8T_DIV8_BITS 3
`define D8T_DIV64_BITS 6
`define D8T_DIV8192_BITS 13
`endif

// file: core/d8t_presc.v
// Free-running prescaler giving one-cycle ticks at the falling edge of
// the divided clocks. Assumes a single clock and synchronous reset.
`include "d8t_map.vh"
module d8t_presc #(
	parameter W = `D8T_DIV8192_BITS
) (
	// Clock and control
	input wire i_clk_sys,
	input wire i_rst,
	input wire i_ce,
	input wire i_run,
	// Ticks
	output wire o_tick8,
	output wire o_tick64,
	output wire o_tick8192
);

	reg [W-1:0] div_r;

	// ==========================================================
	// Divider
	always @(posedge i_clk_sys) begin
		if (i_rst) begin
			div_r <= {W{1'b0}};
		end else if (i_ce && i_run) begin
			div_r <= div_r + {{(W-1){1'b0}}, 1'b1};
		end
	end

	// Divided msb falls when its low bits are all ones
	assign o_tick8 = i_run && (&div_r[`D8T_DIV8_BITS-1:0]);
	assign o_tick64 = i_run && (&div_r[`D8T_DIV64_BITS-1:0]);
	assign o_tick8192 = i_run && (&div_r[`D8T_DIV8192_BITS-1:0]);

endmodule

// file: core/d8t_sync.v
// Two-flop synchronisers with edge detection for the timer's pins.
// Assumes pins are asynchronous to i_clk_sys.
module d8t_sync #(
	parameter W = 4
) (
	// Clock and control
	input wire i_clk_sys,
	input wire i_rst,
	input wire i_ce,
	// Pins
	input wire [W-1:0] i_pin,
	// Edges
	output wire [W-1:0] o_rise,
	output wire [W-1:0] o_fall
);

	reg [W-1:0] meta_r;
	reg [W-1:0] sync_r;
	reg [W-1:0] prev_r;

	// ==========================================================
	// Synchroniser and edge history
	always @(posedge i_clk_sys) begin
		if (i_rst) begin
			meta_r <= {W{1'b0}};
			sync_r <= {W{1'b0}};
			prev_r <= {W{1'b0}};
		end else if (i_ce) begin
			meta_r <= i_pin;
			sync_r <= meta_r;
			prev_r <= sync_r;
		end
	end

	assign o_rise = sync_r & ~prev_r;
	assign o_fall = ~sync_r & prev_r;

endmodule

// file: core/d8t_timer.v
// Dual 8-bit timer: two counters, two constant registers each, compare
// outputs, flags and cascade modes, reached over the CPU byte/word port.
// Assumes i_hw_standby comes from on-chip logic on i_clk_sys.
//
// Function
// - Two channels, each an 8-bit counter compared with constants A and B.
// - Count source is clock/8, /64, /8192 or the external clock pin.
// - Counter clears on match A, match B or external reset as selected.
// - Output pin is driven from combined A and B match events.
// - Cascade mode joins counters, channel 0 high byte, channel 1 low.
// - Compare-match count mode: channel 1 counts channel 0 match A.
// - Match A, match B and overflow requests per channel are independent.
// - Module stop is set after reset; registers accessible once cleared.
// - Per channel one output, one clock input, one clear input pin.
// - Flag bits 7..5 are cleared by writing zero; writing one does nothing.
// - Register pairs accessible as one word, channel 0 in upper byte.
// - Counter increments on selected source; CPU reads or writes it any time.
// - Wrap from all ones to zero sets the overflow flag.
// - Counters initialise to zero on reset and hardware standby.
// - Equality with constant A sets match A flag, suppressed while A written.
// - Equality with constant B sets match B flag, suppressed while B written.
// - Output reaction to A and B each follows its own 2-bit select.
// - Constant registers initialise to all ones on reset and standby.
// - Internal clocks count on falling edge; external rising, falling or both.
// - Clear select 00 none, 01 match A, 10 match B, 11 external rise.
// - Each request forwarded only while its enable is set; enables reset zero.
`include "d8t_map.vh"
module d8t_timer (
	// Clock, reset, enable
	input wire i_clk_sys,
	input wire i_rst,
	input wire i_ce,
	input wire i_hw_standby,
	// CPU register port
	input wire [15:0] i_addr,
	input wire i_wr,
	input wire i_rd,
	input wire i_word,
	input wire [15:0] i_wdata,
	output reg [15:0] o_rdata,
	// Channel pins
	input wire i_ext_clk_in_ch0,
	input wire i_ext_clear_in_ch0,
	output wire o_wave_out_ch0,
	input wire i_ext_clk_in_ch1,
	input wire i_ext_clear_in_ch1,
	output wire o_wave_out_ch1,
	// Interrupt requests, bit 0 channel 0
	output wire [1:0] o_match_a_irq,
	output wire [1:0] o_match_b_irq,
	output wire [1:0] o_overflow_irq
);

	// ==========================================================
	// Common control and decode
	wire init = i_rst || i_hw_standby;
	reg [15:0] module_stop_control_r;
	wire run = ~module_stop_control_r[`D8T_MSTP_BIT];
	wire mstp_hit = ({i_addr[15:1], 1'b0} == `D8T_MSTP_ADDR);
	wire tmr_hit = (i_addr[15:4] == `D8T_BLOCK_HI) && (i_addr[3:1] <= `D8T_IDX_CNT);
	wire acc_ok = tmr_hit && run;
	wire [2:0] rsel = i_addr[3:1];
	wire [1:0] lane;
	wire [15:0] rd_all;
	wire [1:0] wave_all;
	wire [1:0] ovf_ev;
	wire [1:0] cma_ev;
	reg ovf1_ev_r;
	reg cma0_ev_r;

	// Word access covers both lanes, byte access the addressed one
	assign lane[0] = i_word || !i_addr[0];
	assign lane[1] = i_word || i_addr[0];

	// ==========================================================
	// Module stop control
	always @(posedge i_clk_sys) begin
		if (init) begin
			module_stop_control_r <= `D8T_MSTP_RST;
		end else if (i_ce && i_wr && mstp_hit) begin
			if (i_word) begin
				module_stop_control_r <= i_wdata;
			end else if (!i_addr[0]) begin
				module_stop_control_r[15:8] <= i_wdata[7:0];
			end else begin
				module_stop_control_r[7:0] <= i_wdata[7:0];
			end
		end
	end

	// ==========================================================
	// Shared prescaler and pin synchronisers
	wire t8;
	wire t64;
	wire t8192;
	wire [3:0] pin_rise;
	wire [3:0] pin_fall;

	d8t_presc #(
		.W(`D8T_DIV8192_BITS)
	) u_presc (
		.i_clk_sys(i_clk_sys),
		.i_rst(init),
		.i_ce(i_ce),
		.i_run(run),
		.o_tick8(t8),
		.o_tick64(t64),
		.o_tick8192(t8192)
	);

	d8t_sync #(
		.W(4)
	) u_sync (
		.i_clk_sys(i_clk_sys),
		.i_rst(init),
		.i_ce(i_ce),
		.i_pin({i_ext_clear_in_ch1, i_ext_clk_in_ch1, i_ext_clear_in_ch0, i_ext_clk_in_ch0}),
		.o_rise(pin_rise),
		.o_fall(pin_fall)
	);

	// Cascade events registered to break the loop between channels
	always @(posedge i_clk_sys) begin
		if (init) begin
			ovf1_ev_r <= 1'b0;
			cma0_ev_r <= 1'b0;
		end else if (i_ce) begin
			ovf1_ev_r <= ovf_ev[1];
			cma0_ev_r <= cma_ev[0];
		end
	end

	// Output select action on the current pin level
	function wave_act;
		input [1:0] sel;
		input cur;
		begin
			case (sel)
				`D8T_OS_LOW: wave_act = 1'b0;
				`D8T_OS_HIGH: wave_act = 1'b1;
				`D8T_OS_TOGGLE: wave_act = ~cur;
				default: wave_act = cur;
			endcase
		end
	endfunction

	// ==========================================================
	// Channels
	genvar c;
	generate
		for (c = 0; c < 2; c = c + 1) begin : g_ch
			reg [7:0] timer_control_r;
			reg [7:0] constant_a_r;
			reg [7:0] constant_b_r;
			reg [7:0] up_counter_r;
			reg match_a_flag_r;
			reg match_b_flag_r;
			reg overflow_flag_r;
			reg [3:0] out_sel_r;
			reg wave_r;
			reg tick;
			reg clr;
			reg [7:0] rd_byte;
			reg [7:0] cnt_nxt;
			reg wave_nxt;
			wire [7:0] wd = (i_word && c == 0) ? i_wdata[15:8] : i_wdata[7:0];
			wire wr_ch = i_wr && acc_ok && lane[c];
			wire wr_tcr = wr_ch && (rsel == `D8T_IDX_TCR);
			wire wr_control_status = wr_ch && (rsel == `D8T_IDX_CONTROL_STATUS);
			wire wr_cora = wr_ch && (rsel == `D8T_IDX_CORA);
			wire wr_corb = wr_ch && (rsel == `D8T_IDX_CORB);
			wire wr_cnt = wr_ch && (rsel == `D8T_IDX_CNT);
			wire [2:0] cks = timer_control_r[`D8T_TCR_CKS_LO +: 3];
			wire [1:0] cclr = timer_control_r[`D8T_TCR_CCLR_LO +: 2];
			wire ext_rise = pin_rise[2*c];
			wire ext_fall = pin_fall[2*c];
			wire ext_clr = pin_rise[2*c+1];
			wire casc_ev = (c == 0) ? ovf1_ev_r : cma0_ev_r;
			// Match in the last cycle of the matching value
			wire match_a = tick && (up_counter_r == constant_a_r) && !wr_cora;
			wire match_b = tick && (up_counter_r == constant_b_r) && !wr_corb;
			wire ovf = tick && (up_counter_r == `D8T_CNT_MAX) && !clr && !wr_cnt;

			// Count source
			always @* begin
				case (cks)
					`D8T_CKS_DIV8: tick = t8;
					`D8T_CKS_DIV64: tick = t64;
					`D8T_CKS_DIV8192: tick = t8192;
					`D8T_CKS_CASC: tick = casc_ev;
					`D8T_CKS_EXT_RISE: tick = ext_rise;
					`D8T_CKS_EXT_FALL: tick = ext_fall;
					`D8T_CKS_EXT_BOTH: tick = ext_rise || ext_fall;
					default: tick = 1'b0;
				endcase
				if (!run) begin
					tick = 1'b0;
				end
			end

			// Clear source
			always @* begin
				case (cclr)
					`D8T_CCLR_MATCH_A: clr = match_a;
					`D8T_CCLR_MATCH_B: clr = match_b;
					`D8T_CCLR_EXT: clr = ext_clr && run;
					default: clr = 1'b0;
				endcase
			end

			// Counter: clear beats write, write beats increment
			always @* begin
				cnt_nxt = up_counter_r;
				if (clr) begin
					cnt_nxt = `D8T_CNT_RST;
				end else if (wr_cnt) begin
					cnt_nxt = wd;
				end else if (tick) begin
					cnt_nxt = up_counter_r + 8'h01;
				end
			end

			// Wave output, A applied after B so A wins on a tie
			always @* begin
				wave_nxt = wave_r;
				if (match_b) begin
					wave_nxt = wave_act(out_sel_r[`D8T_CONTROL_STATUS_OSB_LO +: 2], wave_nxt);
				end
				if (match_a) begin
					wave_nxt = wave_act(out_sel_r[`D8T_CONTROL_STATUS_OSA_LO +: 2], wave_nxt);
				end
			end

			always @(posedge i_clk_sys) begin
				if (init) begin
					timer_control_r <= `D8T_TCR_RST;
					constant_a_r <= `D8T_COR_RST;
					constant_b_r <= `D8T_COR_RST;
					up_counter_r <= `D8T_CNT_RST;
					match_a_flag_r <= 1'b0;
					match_b_flag_r <= 1'b0;
					overflow_flag_r <= 1'b0;
					out_sel_r <= 4'h0;
					wave_r <= 1'b0;
				end else if (i_ce) begin
					up_counter_r <= cnt_nxt;
					wave_r <= wave_nxt;
					if (wr_tcr) begin
						timer_control_r <= wd;
					end
					if (wr_cora) begin
						constant_a_r <= wd;
					end
					if (wr_corb) begin
						constant_b_r <= wd;
					end
					if (wr_control_status) begin
						out_sel_r <= wd[3:0];
					end
					// Zero write clears, a same-cycle event sets
					match_b_flag_r <= match_b || (match_b_flag_r && !(wr_control_status &&
						!wd[`D8T_CONTROL_STATUS_FLAG_LO+2]));
					match_a_flag_r <= match_a || (match_a_flag_r && !(wr_control_status &&
						!wd[`D8T_CONTROL_STATUS_FLAG_LO+1]));
					overflow_flag_r <= ovf || (overflow_flag_r && !(wr_control_status &&
						!wd[`D8T_CONTROL_STATUS_FLAG_LO]));
				end
			end

			// Register read mux
			always @* begin
				case (rsel)
					`D8T_IDX_TCR: rd_byte = timer_control_r;
					`D8T_IDX_CONTROL_STATUS: rd_byte = {match_b_flag_r, match_a_flag_r, overflow_flag_r,
						(c == 1) ? 1'b1 : 1'b0, out_sel_r};
					`D8T_IDX_CORA: rd_byte = constant_a_r;
					`D8T_IDX_CORB: rd_byte = constant_b_r;
					`D8T_IDX_CNT: rd_byte = up_counter_r;
					default: rd_byte = 8'h00;
				endcase
			end

			assign rd_all[8*(1-c) +: 8] = rd_byte;
			assign wave_all[c] = wave_r;
			assign ovf_ev[c] = ovf;
			assign cma_ev[c] = match_a;
			assign o_match_a_irq[c] = match_a_flag_r && timer_control_r[`D8T_TCR_MATCH_A_IRQ_EN];
			assign o_match_b_irq[c] = match_b_flag_r && timer_control_r[`D8T_TCR_MATCH_B_IRQ_EN];
			assign o_overflow_irq[c] = overflow_flag_r && timer_control_r[`D8T_TCR_OVERFLOW_IRQ_EN];
		end
	endgenerate

	assign o_wave_out_ch0 = wave_all[0];
	assign o_wave_out_ch1 = wave_all[1];

	// ==========================================================
	// Read data register
	always @(posedge i_clk_sys) begin
		if (init) begin
			o_rdata <= 16'h0000;
		end else if (i_ce && i_rd) begin
			if (mstp_hit) begin
				if (i_word) begin
					o_rdata <= module_stop_control_r;
				end else if (!i_addr[0]) begin
					o_rdata <= {8'h00, module_stop_control_r[15:8]};
				end else begin
					o_rdata <= {8'h00, module_stop_control_r[7:0]};
				end
			end else if (acc_ok) begin
				if (i_word) begin
					o_rdata <= rd_all;
				end else if (!i_addr[0]) begin
					o_rdata <= {8'h00, rd_all[15:8]};
				end else begin
					o_rdata <= {8'h00, rd_all[7:0]};
				end
			end else begin
				o_rdata <= 16'h0000;
			end
		end
	end

endmodule

// file: bench/d8t_timer_monitor.sv
// Checker of the dual 8-bit timer, bound to its top module.
// Assumes one clock domain and at most one register access per cycle.
module d8t_timer_monitor (
	// Clock and control
	input wire i_clk_sys,
	input wire i_rst,
	input wire i_ce,
	input wire i_hw_standby,
	// Register port
	input wire [15:0] i_addr,
	input wire i_wr,
	input wire i_rd,
	input wire i_word,
	input wire [15:0] i_wdata,
	input wire [15:0] o_rdata,
	// Pins and requests
	input wire o_wave_out_ch0,
	input wire o_wave_out_ch1,
	input wire [1:0] o_match_a_irq,
	input wire [1:0] o_match_b_irq,
	input wire [1:0] o_overflow_irq
);
	timeunit 1ns;
	timeprecision 1ps;
	wire rst_any = i_rst | i_hw_standby;
	wire wr_go = i_wr & i_ce;
	wire rd_go = i_rd & i_ce;
	wire mstp_wr = wr_go & (i_addr[15:1] == 15'h7f9e);
	wire [2:0] irq_ch1 = {o_match_a_irq[1], o_match_b_irq[1], o_overflow_irq[1]};
	wire [7:0] quiet_w = {o_wave_out_ch0, o_wave_out_ch1, o_match_a_irq, o_match_b_irq,
		o_overflow_irq};
	reg [15:0] mstp_r;
	// ====================
	// Module stop shadow
	always @(posedge i_clk_sys) begin
		if (rst_any) begin
			mstp_r <= 16'h3fff;
		end else if (mstp_wr & i_word) begin
			mstp_r <= i_wdata;
		end else if (mstp_wr & ~i_addr[0]) begin
			mstp_r[15:8] <= i_wdata[7:0];
		end else if (mstp_wr) begin
			mstp_r[7:0] <= i_wdata[7:0];
		end
	end
	default clocking @(posedge i_clk_sys);
	endclocking
	default disable iff (rst_any);
	// ====================
	// Properties
	sequence s_mstp_rd;
		rd_go && i_addr == 16'hff3c && i_word;
	endsequence
	sequence s_tmr_rd;
		rd_go && i_addr[15:4] == 12'hffb && i_addr[3:0] <= 4'h9;
	endsequence
	property p_mstp_read;
		s_mstp_rd |=> o_rdata == mstp_r;
	endproperty
	property p_stop_read;
		s_tmr_rd and mstp_r[12] |=> o_rdata == 16'h0000;
	endproperty
	property p_stop_quiet;
		mstp_r[12] && !mstp_wr |=> $stable(quiet_w);
	endproperty
	property p_a_hold;
		!wr_go |=> (o_match_a_irq & $past(o_match_a_irq)) == $past(o_match_a_irq);
	endproperty
	property p_b_hold;
		!wr_go |=> (o_match_b_irq & $past(o_match_b_irq)) == $past(o_match_b_irq);
	endproperty
	property p_ovf_hold;
		!wr_go |=> (o_overflow_irq & $past(o_overflow_irq)) == $past(o_overflow_irq);
	endproperty
	property p_ones_keep;
		wr_go && !i_word && i_addr == 16'hffb3 && i_wdata[7:5] == 3'h7
			|=> (irq_ch1 & $past(irq_ch1)) == $past(irq_ch1);
	endproperty
	property p_rdata_hold;
		!rd_go |=> $stable(o_rdata);
	endproperty
	a_mstp_read: assert property (p_mstp_read) else $error("stop reg read wrong");
	a_stop_read: assert property (p_stop_read) else $error("read while stopped");
	a_stop_quiet: assert property (p_stop_quiet) else $error("active while stopped");
	a_a_hold: assert property (p_a_hold) else $error("match a request lost");
	a_b_hold: assert property (p_b_hold) else $error("match b request lost");
	a_ovf_hold: assert property (p_ovf_hold) else $error("overflow request lost");
	a_ones_keep: assert property (p_ones_keep) else $error("flag cleared by one");
	a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
endmodule

bind d8t_timer d8t_timer_monitor mon_u (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_ce(i_ce),
	.i_hw_standby(i_hw_standby), .i_addr(i_addr), .i_wr(i_wr), .i_rd(i_rd), .i_word(i_word),
	.i_wdata(i_wdata), .o_rdata(o_rdata), .o_wave_out_ch0(o_wave_out_ch0),
	.o_wave_out_ch1(o_wave_out_ch1), .o_match_a_irq(o_match_a_irq),
	.o_match_b_irq(o_match_b_irq), .o_overflow_irq(o_overflow_irq));

// file: bench/d8t_pins.sv
// Far-side pin model: external count clock and clear inputs.
// Assumes the timer synchronises both pins to i_clk_sys.
module d8t_pins (
	// Clock
	input wire i_clk_sys,
	// Pins, bit 0 channel 0
	output logic [1:0] o_ext_clk,
	output logic [1:0] o_ext_clear
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		o_ext_clk = 2'h0;
		o_ext_clear = 2'h0;
	end
	// Pulses wide enough for the synchroniser
	task automatic clk_pulses(input int ch, input int n);
		repeat (n) begin
			@(posedge i_clk_sys);
			o_ext_clk[ch] <= 1'b1;
			repeat (4) @(posedge i_clk_sys);
			o_ext_clk[ch] <= 1'b0;
			repeat (4) @(posedge i_clk_sys);
		end
	endtask
	task automatic clear_pulse(input int ch);
		@(posedge i_clk_sys);
		o_ext_clear[ch] <= 1'b1;
		repeat (4) @(posedge i_clk_sys);
		o_ext_clear[ch] <= 1'b0;
		repeat (4) @(posedge i_clk_sys);
	endtask
endmodule

// file: bench/d8t_timer_bench.sv
// Self-checking bench of the dual 8-bit timer with its pin model.
// Assumes the byte/word register port and one 40 MHz clock.
module d8t_timer_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_clk_sys, i_rst, i_ce, i_hw_standby, i_wr, i_rd, i_word;
	logic [15:0] i_addr, i_wdata, rd_val;
	wire [15:0] o_rdata;
	wire o_wave_out_ch0, o_wave_out_ch1;
	wire [1:0] o_match_a_irq, o_match_b_irq, o_overflow_irq, ext_clk, ext_clear;
	int fail_count, samples_checked;

	d8t_timer dut_u (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_ce(i_ce),
		.i_hw_standby(i_hw_standby), .i_addr(i_addr), .i_wr(i_wr), .i_rd(i_rd),
		.i_word(i_word), .i_wdata(i_wdata), .o_rdata(o_rdata),
		.i_ext_clk_in_ch0(ext_clk[0]), .i_ext_clear_in_ch0(ext_clear[0]),
		.o_wave_out_ch0(o_wave_out_ch0), .i_ext_clk_in_ch1(ext_clk[1]),
		.i_ext_clear_in_ch1(ext_clear[1]), .o_wave_out_ch1(o_wave_out_ch1),
		.o_match_a_irq(o_match_a_irq), .o_match_b_irq(o_match_b_irq),
		.o_overflow_irq(o_overflow_irq));
	d8t_pins pins_u (.i_clk_sys(i_clk_sys), .o_ext_clk(ext_clk), .o_ext_clear(ext_clear));

	// ====================
	// Bus and compare tasks
	task automatic reg_wr(input logic [15:0] a, input logic [15:0] d, input logic w);
		@(posedge i_clk_sys);
		i_addr <= a;
		i_wdata <= d;
		i_word <= w;
		i_wr <= 1'b1;
		@(posedge i_clk_sys);
		i_wr <= 1'b0;
		#1;
	endtask
	task automatic reg_rd(input logic [15:0] a, input logic w);
		@(posedge i_clk_sys);
		i_addr <= a;
		i_word <= w;
		i_rd <= 1'b1;
		@(posedge i_clk_sys);
		i_rd <= 1'b0;
		#1;
		rd_val = o_rdata;
	endtask
	task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_rng(input int got, input int lo, input int hi);
		samples_checked++;
		if (got < lo || got > hi) begin
			fail_count++;
			$display("mismatch at %0t: count %0d not in %0d..%0d", $time, got, lo, hi);
		end
	endtask
	task automatic wait_wave(input logic lvl, output int n);
		n = 0;
		while (o_wave_out_ch1 !== lvl && n < 200) begin
			@(posedge i_clk_sys);
			#1;
			n++;
		end
	endtask

	// ====================
	// Scenarios
	task automatic test_reset_regs();
		logic [15:0] exp [5] = '{16'h0000, 16'h0010, 16'hffff, 16'hffff, 16'h0000};
		reg_wr(16'hffb4, 16'h1111, 1'b1);
		reg_rd(16'hffb0, 1'b1);
		chk_val(rd_val, 16'h0000);
		reg_rd(16'hff3c, 1'b1);
		chk_val(rd_val, 16'h3fff);
		reg_wr(16'hff3c, 16'h2fff, 1'b1);
		for (int i = 0; i < 5; i++) begin
			reg_rd(16'hffb0 + 16'(2 * i), 1'b1);
			chk_val(rd_val, exp[i]);
		end
		reg_rd(16'hffa0, 1'b1);
		chk_val(rd_val, 16'h0000);
		$display("test_reset_regs done");
	endtask
	task automatic test_word_pair();
		reg_wr(16'hffb4, 16'h1234, 1'b1);
		reg_rd(16'hffb4, 1'b0);
		chk_val(rd_val, 16'h0012);
		reg_rd(16'hffb5, 1'b0);
		chk_val(rd_val, 16'h0034);
		$display("test_word_pair done");
	endtask
	task automatic test_duty();
		int n;
		reg_wr(16'hffb4, 16'h1204, 1'b1);
		reg_wr(16'hffb6, 16'hff01, 1'b1);
		reg_wr(16'hffb3, 16'h0009, 1'b0);
		reg_wr(16'hffb1, 16'h0049, 1'b0);
		wait_wave(1'b1, n);
		wait_wave(1'b0, n);
		chk_rng(n, 24, 24);
		wait_wave(1'b1, n);
		chk_rng(n, 16, 16);
		reg_rd(16'hffb3, 1'b0);
		chk_val(rd_val, 16'h00d9);
		chk_val(16'(o_match_a_irq), 16'h0002);
		chk_val(16'(o_match_b_irq), 16'h0000);
		reg_wr(16'hffb1, 16'h0040, 1'b0);
		reg_wr(16'hffb3, 16'h00ff, 1'b0);
		chk_val(16'(o_match_a_irq), 16'h0002);
		reg_wr(16'hffb3, 16'h0079, 1'b0);
		chk_val(16'(o_match_a_irq), 16'h0002);
		reg_rd(16'hffb3, 1'b0);
		chk_val(rd_val, 16'h0059);
		reg_wr(16'hffb3, 16'h0019, 1'b0);
		chk_val(16'(o_match_a_irq), 16'h0000);
		$display("test_duty done");
	endtask
	task automatic test_overflow();
		int n;
		reg_wr(16'hffb8, 16'h00fe, 1'b0);
		reg_wr(16'hffb2, 16'h0008, 1'b0);
		reg_wr(16'hffb0, 16'h0022, 1'b0);
		n = 0;
		while (o_overflow_irq[0] !== 1'b1 && n < 300) begin
			@(posedge i_clk_sys);
			#1;
			n++;
		end
		chk_rng(n, 64, 130);
		chk_val(16'(o_wave_out_ch0), 16'h0001);
		reg_rd(16'hffb2, 1'b0);
		chk_val(rd_val & 16'h00a0, 16'h00a0);
		reg_wr(16'hffb0, 16'h0000, 1'b0);
		$display("test_overflow done");
	endtask
	task automatic test_cascade();
		reg_wr(16'hffb8, 16'h00fe, 1'b1);
		reg_wr(16'hffb0, 16'h0401, 1'b1);
		repeat (20) @(posedge i_clk_sys);
		reg_rd(16'hffb8, 1'b1);
		chk_val(rd_val & 16'hfffe, 16'h0100);
		reg_wr(16'hffb8, 16'h0000, 1'b1);
		reg_wr(16'hffb4, 16'h0104, 1'b1);
		reg_wr(16'hffb0, 16'h0904, 1'b1);
		repeat (160) @(posedge i_clk_sys);
		reg_rd(16'hffb9, 1'b0);
		chk_val(16'(rd_val >= 16'h0009 && rd_val <= 16'h000b), 16'h0001);
		$display("test_cascade done");
	endtask
	task automatic test_ext_pins();
		reg_wr(16'hffb0, 16'h0005, 1'b0);
		reg_wr(16'hffb8, 16'h0000, 1'b0);
		for (int c = 5; c < 8; c++) begin
			reg_wr(16'hffb0, 16'(c), 1'b0);
			pins_u.clk_pulses(0, 1);
		end
		reg_rd(16'hffb8, 1'b0);
		chk_val(rd_val, 16'h0004);
		reg_wr(16'hffb0, 16'h001d, 1'b0);
		pins_u.clear_pulse(0);
		reg_rd(16'hffb8, 1'b0);
		chk_val(rd_val, 16'h0000);
		$display("test_ext_pins done");
	endtask

	task automatic test_standby_ce();
		@(posedge i_clk_sys);
		i_ce <= 1'b0;
		pins_u.clk_pulses(0, 1);
		i_ce <= 1'b1;
		reg_rd(16'hffb8, 1'b0);
		chk_val(rd_val, 16'h0000);
		reg_wr(16'hffb4, 16'h5566, 1'b1);
		reg_wr(16'hffb8, 16'h1234, 1'b1);
		@(posedge i_clk_sys);
		i_hw_standby <= 1'b1;
		repeat (2) @(posedge i_clk_sys);
		i_hw_standby <= 1'b0;
		reg_rd(16'hff3c, 1'b1);
		chk_val(rd_val, 16'h3fff);
		reg_wr(16'hff3c, 16'h2fff, 1'b1);
		reg_rd(16'hffb4, 1'b1);
		chk_val(rd_val, 16'hffff);
		reg_rd(16'hffb8, 1'b1);
		chk_val(rd_val, 16'h0000);
		$display("test_standby_ce done");
	endtask

	task automatic final_report();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	initial begin
		i_clk_sys = 1'b0;
		forever #12.5 i_clk_sys = ~i_clk_sys;
	end
	initial begin
		repeat (6000) @(posedge i_clk_sys);
		fail_count++;
		$display("mismatch at %0t: watchdog expired", $time);
		final_report();
	end
	initial begin
		fail_count = 0;
		samples_checked = 0;
		i_rst = 1'b1;
		i_ce = 1'b1;
		i_hw_standby = 1'b0;
		i_wr = 1'b0;
		i_rd = 1'b0;
		i_word = 1'b0;
		i_addr = 16'h0000;
		i_wdata = 16'h0000;
		repeat (12) @(posedge i_clk_sys);
		i_rst <= 1'b0;
		test_reset_regs();
		test_word_pair();
		test_duty();
		test_overflow();
		test_cascade();
		test_ext_pins();
		test_standby_ce();
		final_report();
	end
endmodule
